// [src/btu_pkg.sv]
package btu_pkg;
    localparam int NUM_BP = 4;
    localparam int IDX_W = 2;
    localparam logic [11:0] CSR_SELECT = 12'h07a0;
    localparam logic [11:0] CSR_CONTROL = 12'h07a1;
    localparam logic [11:0] CSR_ADDRESS = 12'h07a2;
    localparam logic [11:0] CSR_RESERVED = 12'h07a3;
    localparam logic [3:0] TYPE_BREAKPOINT = 4'h1;
    localparam logic [3:0] TYPE_NONE = 4'h0;
    localparam logic [7:0] ACTION_TRAP = 8'h00;
    localparam logic [3:0] MATCH_EXACT = 4'h0;
    localparam logic [3:0] MATCH_RANGE_TOP = 4'h1;
    localparam logic [3:0] MATCH_NAPOT = 4'h2;
    localparam logic [4:0] AMASK_MAX = 5'h1f;
    localparam logic [31:0] CAUSE_BREAKPOINT = 32'h0000_0003;
    localparam int TYPE_LSB = 28;
    localparam int AMASK_LSB = 23;
    localparam int ACTION_LSB = 11;
    localparam int MATCH_LSB = 7;
    localparam int PRIV_M_BIT = 6;
    localparam int PRIV_H_BIT = 5;
    localparam int PRIV_S_BIT = 4;
    localparam int PRIV_U_BIT = 3;
    localparam int ACC_R_BIT = 2;
    localparam int ACC_W_BIT = 1;
    localparam int ACC_X_BIT = 0;
    localparam logic [1:0] PRIV_U = 2'h0;
    localparam logic [1:0] PRIV_S = 2'h1;
    localparam logic [1:0] PRIV_H = 2'h2;
    localparam logic [1:0] PRIV_M = 2'h3;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// [src/btu_match.sv]
`timescale 1ns/1ps
`default_nettype none
// One address comparator: exact or unary power-of-two mask
module btu_match (
    input wire logic [31:0] addr_i,
    input wire logic [31:0] last_i,
    input wire logic [31:0] bp_addr_i,
    input wire logic napot_i,
    output logic hit_o
);
    logic [31:0] mask;
    logic hit_first;
    logic hit_last;
    logic hit_span;
    always_comb begin
        // Trailing ones plus the first zero drop out of the compare
        mask = 32'hffff_ffff;
        if (napot_i) begin
            mask = ~(bp_addr_i ^ (bp_addr_i + 32'h0000_0001));
        end
        hit_first = ((addr_i ^ bp_addr_i) & mask) == 32'h0000_0000;
        hit_last = ((last_i ^ bp_addr_i) & mask) == 32'h0000_0000;
        // Region is contiguous, so straddling it also means a byte inside
        hit_span = ((addr_i & mask) < (bp_addr_i & mask)) && ((last_i & mask) > (bp_addr_i & mask));
        hit_o = hit_first || hit_last || hit_span;
    end
endmodule // btu_match
`default_nettype wire

// [src/btu_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module btu_unit (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic csr_valid_i,
    input wire logic csr_write_i,
    input wire logic [11:0] csr_addr_i,
    input wire logic [31:0] csr_wdata_i,
    input wire logic csr_debug_mode_i,
    input wire logic acc_valid_i,
    input wire logic [31:0] acc_addr_i,
    input wire logic [2:0] acc_bytes_m1_i,
    input wire logic acc_load_i,
    input wire logic acc_store_i,
    input wire logic acc_fetch_i,
    input wire logic [1:0] acc_priv_i,
    output logic [31:0] csr_rdata_o,
    output logic csr_ready_o,
    output logic csr_illegal_o,
    output logic trap_valid_o,
    output logic trap_to_debug_o,
    output logic [31:0] trap_cause_o,
    output logic [31:0] trap_badaddr_o,
    output logic [btu_pkg::NUM_BP-1:0] bp_hit_o
);
    typedef struct packed {
        logic sel_mode;
        logic [btu_pkg::IDX_W-1:0] sel_idx;
        logic [btu_pkg::NUM_BP-1:0] dbg_owned;
        logic [btu_pkg::NUM_BP-1:0][3:0] kind;
        logic [btu_pkg::NUM_BP-1:0][3:0] priv_en;
        logic [btu_pkg::NUM_BP-1:0][2:0] acc_en;
        logic [btu_pkg::NUM_BP-1:0][31:0] baddr;
        logic [31:0] rdata;
        logic ready;
        logic illegal;
        logic trap;
        logic to_dbg;
        logic [31:0] cause;
        logic [31:0] badaddr;
        logic [btu_pkg::NUM_BP-1:0] hit;
    } btu_state_t;

    btu_state_t st;
    btu_state_t next_st;
    logic [31:0] last_addr;
    logic [btu_pkg::NUM_BP-1:0] raw_hit;
    logic [btu_pkg::NUM_BP-1:0] visible;
    logic [btu_pkg::NUM_BP-1:0] fire;

    assign last_addr = acc_addr_i + {{29{1'b0}}, acc_bytes_m1_i};

    // ----------------------------------------
    // Per-breakpoint comparators and qualifiers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < btu_pkg::NUM_BP; g++) begin : g_bp
            logic [3:0] pv;
            logic legal_kind;
            logic pair_hit;
            logic cond_g;
            logic fire_g;
            // One driver per bit: each slot owns its own local result
            assign fire[g] = fire_g;
            btu_match u_match (
                .addr_i(acc_addr_i),
                .last_i(last_addr),
                .bp_addr_i(st.baddr[g]),
                .napot_i(st.kind[g] == btu_pkg::MATCH_NAPOT),
                .hit_o(raw_hit[g])
            );
            always_comb begin
                pv = st.priv_en[g];
                // Each set bit admits its own case; nothing set means no restriction
                cond_g = ((st.acc_en[g] == 3'h0)
                    || (st.acc_en[g][btu_pkg::ACC_R_BIT] && acc_load_i)
                    || (st.acc_en[g][btu_pkg::ACC_W_BIT] && acc_store_i)
                    || (st.acc_en[g][btu_pkg::ACC_X_BIT] && acc_fetch_i))
                    && ((pv == 4'h0)
                    || (pv[btu_pkg::PRIV_M_BIT-3] && acc_priv_i == btu_pkg::PRIV_M)
                    || (pv[btu_pkg::PRIV_H_BIT-3] && acc_priv_i == btu_pkg::PRIV_H)
                    || (pv[btu_pkg::PRIV_S_BIT-3] && acc_priv_i == btu_pkg::PRIV_S)
                    || (pv[btu_pkg::PRIV_U_BIT-3] && acc_priv_i == btu_pkg::PRIV_U));
                legal_kind = st.kind[g] <= btu_pkg::MATCH_NAPOT;
                pair_hit = 1'b0;
                if (g > 0) begin
                    // Lower holds first byte, this one holds one past last
                    pair_hit = (last_addr >= st.baddr[(g > 0) ? g - 1 : 0]) && (acc_addr_i < st.baddr[g]);
                end
                // Lower neighbour's control is not consulted for the pair
                if (st.kind[g] == btu_pkg::MATCH_RANGE_TOP) begin
                    fire_g = acc_valid_i && legal_kind && pair_hit && cond_g;
                end else begin
                    fire_g = acc_valid_i && legal_kind && raw_hit[g] && cond_g;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [btu_pkg::IDX_W-1:0] i;
        logic data_acc;
        logic [3:0] wkind;
        next_st = st;
        i = st.sel_idx;
        data_acc = (csr_addr_i == btu_pkg::CSR_CONTROL) || (csr_addr_i == btu_pkg::CSR_ADDRESS)
            || (csr_addr_i == btu_pkg::CSR_RESERVED);
        wkind = csr_wdata_i[btu_pkg::MATCH_LSB +: 4];
        // Debug view is closed to machine code
        for (int k = 0; k < btu_pkg::NUM_BP; k++) begin
            visible[k] = csr_debug_mode_i || !st.dbg_owned[k];
        end
        next_st.ready = 1'b0;
        next_st.illegal = 1'b0;
        next_st.rdata = btu_pkg::RESET_WORD;
        if (csr_valid_i) begin
            next_st.ready = 1'b1;
            if (data_acc && !csr_debug_mode_i && !st.sel_mode) begin
                next_st.illegal = 1'b1;
            end else if (csr_addr_i == btu_pkg::CSR_SELECT) begin
                next_st.rdata = {st.sel_mode, {(31 - btu_pkg::IDX_W){1'b0}}, st.sel_idx};
                if (csr_write_i) begin
                    // Only debug code may pick the debug view
                    next_st.sel_mode = csr_wdata_i[31] || !csr_debug_mode_i;
                    // Unimplemented upper index bits are simply not stored
                    next_st.sel_idx = csr_wdata_i[btu_pkg::IDX_W-1:0];
                end
            end else if (csr_addr_i == btu_pkg::CSR_CONTROL) begin
                if (visible[i]) begin
                    next_st.rdata[btu_pkg::TYPE_LSB +: 4] = btu_pkg::TYPE_BREAKPOINT;
                    next_st.rdata[btu_pkg::AMASK_LSB +: 5] = btu_pkg::AMASK_MAX;
                    next_st.rdata[btu_pkg::ACTION_LSB +: 8] = btu_pkg::ACTION_TRAP;
                    next_st.rdata[btu_pkg::MATCH_LSB +: 4] = st.kind[i];
                    next_st.rdata[btu_pkg::PRIV_U_BIT +: 4] = st.priv_en[i];
                    next_st.rdata[btu_pkg::ACC_X_BIT +: 3] = st.acc_en[i];
                end
                if (csr_write_i && visible[i]) begin
                    // Reserved codes fall back to exact rather than stick
                    next_st.kind[i] = (wkind <= btu_pkg::MATCH_NAPOT) ? wkind : btu_pkg::MATCH_EXACT;
                    if (i == '0) begin
                        next_st.kind[i][0] = 1'b0;
                    end
                    next_st.priv_en[i] = csr_wdata_i[btu_pkg::PRIV_U_BIT +: 4];
                    next_st.acc_en[i] = csr_wdata_i[btu_pkg::ACC_X_BIT +: 3];
                    // Claiming from the debug view hides it from machine code
                    next_st.dbg_owned[i] = !st.sel_mode;
                end
            end else if (csr_addr_i == btu_pkg::CSR_ADDRESS) begin
                if (visible[i]) begin
                    next_st.rdata = st.baddr[i];
                end
                if (csr_write_i && visible[i]) begin
                    next_st.baddr[i] = csr_wdata_i;
                end
            end
        end
        // Lowest numbered firing breakpoint owns the trap
        next_st.trap = 1'b0;
        next_st.to_dbg = 1'b0;
        next_st.cause = btu_pkg::RESET_WORD;
        next_st.badaddr = btu_pkg::RESET_WORD;
        next_st.hit = fire;
        for (int k = btu_pkg::NUM_BP - 1; k >= 0; k--) begin
            // A hidden breakpoint still fires for its debug owner
            if (fire[k]) begin
                next_st.trap = 1'b1;
                next_st.to_dbg = st.dbg_owned[k];
                if (st.dbg_owned[k]) begin
                    next_st.cause = btu_pkg::RESET_WORD;
                    next_st.badaddr = btu_pkg::RESET_WORD;
                end else begin
                    next_st.cause = btu_pkg::CAUSE_BREAKPOINT;
                    next_st.badaddr = acc_addr_i;
                end
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
            st.sel_mode <= 1'b1;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign csr_rdata_o = st.rdata;
    assign csr_ready_o = st.ready;
    assign csr_illegal_o = st.illegal;
    assign trap_valid_o = st.trap;
    assign trap_to_debug_o = st.to_dbg;
    assign trap_cause_o = st.cause;
    assign trap_badaddr_o = st.badaddr;
    assign bp_hit_o = st.hit;
endmodule // btu_unit
`default_nettype wire

// [sim/btu_unit_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module btu_unit_properties (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic csr_valid_i,
    input wire logic csr_write_i,
    input wire logic [11:0] csr_addr_i,
    input wire logic acc_valid_i,
    input wire logic [31:0] acc_addr_i,
    input wire logic [31:0] csr_rdata_o,
    input wire logic csr_ready_o,
    input wire logic csr_illegal_o,
    input wire logic trap_valid_o,
    input wire logic trap_to_debug_o,
    input wire logic [31:0] trap_cause_o,
    input wire logic [31:0] trap_badaddr_o,
    input wire logic [btu_pkg::NUM_BP-1:0] bp_hit_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic rd_ctl;
    assign rd_ctl = ce_i && csr_valid_i && !csr_write_i && csr_addr_i == btu_pkg::CSR_CONTROL;
    csr_answer_a: assert property (ce_i && csr_valid_i |=> csr_ready_o)
        else $error("csr access not answered");
    csr_quiet_a: assert property (ce_i && !csr_valid_i |=> !csr_ready_o)
        else $error("csr answer without access");
    reserved_zero_a: assert property (ce_i && csr_valid_i && csr_addr_i == btu_pkg::CSR_RESERVED |=>
        csr_rdata_o == 32'h0000_0000) else $error("reserved csr not zero");
    type_field_a: assert property (rd_ctl |=> csr_illegal_o || csr_rdata_o == 32'h0000_0000 ||
        csr_rdata_o[31:23] == {btu_pkg::TYPE_BREAKPOINT, btu_pkg::AMASK_MAX}) else $error("bad type field");
    action_zero_a: assert property (rd_ctl |=> csr_rdata_o[18:11] == btu_pkg::ACTION_TRAP)
        else $error("action field not zero");
    illegal_read_a: assert property (csr_illegal_o |-> csr_ready_o && csr_rdata_o == 32'h0000_0000)
        else $error("illegal access leaks data");
    hit_trap_a: assert property (trap_valid_o == (|bp_hit_o))
        else $error("trap and hits disagree");
    machine_trap_a: assert property (ce_i && acc_valid_i ##1 trap_valid_o && !trap_to_debug_o |->
        trap_cause_o == btu_pkg::CAUSE_BREAKPOINT && trap_badaddr_o == $past(acc_addr_i)) else $error("bad cause");
    debug_trap_a: assert property (trap_valid_o && trap_to_debug_o |->
        trap_cause_o == 32'h0000_0000 && trap_badaddr_o == 32'h0000_0000) else $error("debug trap alters state");
    cover property (csr_illegal_o);
    cover property (trap_valid_o && trap_to_debug_o);
    cover property ($countones(bp_hit_o) > 1);
endmodule // btu_unit_properties
bind btu_unit btu_unit_properties i_props (.*);
`default_nettype wire

// [sim/btu_hart_model.sv]
`timescale 1ns/1ps
`default_nettype none
module btu_hart_model (
    input wire logic clk_i,
    output logic acc_valid_o,
    output logic [31:0] acc_addr_o,
    output logic [2:0] acc_bytes_m1_o,
    output logic [2:0] acc_kind_o,
    output logic [1:0] acc_priv_o
);
    initial begin
        acc_valid_o = 1'b0;
        {acc_addr_o, acc_bytes_m1_o, acc_kind_o, acc_priv_o} = '0;
    end
    // Kind bits are load, store, fetch; one access per call
    task automatic issue(input logic [31:0] a, input logic [2:0] n, input logic [2:0] k, input logic [1:0] p);
        @(posedge clk_i);
        #1;
        acc_valid_o = 1'b1;
        {acc_addr_o, acc_bytes_m1_o, acc_kind_o, acc_priv_o} = {a, n, k, p};
        @(posedge clk_i);
        #1;
        acc_valid_o = 1'b0;
        // Released lines must not keep showing the old access
        {acc_addr_o, acc_bytes_m1_o, acc_kind_o, acc_priv_o} = ~{a, n, k, p};
    endtask
endmodule // btu_hart_model
`default_nettype wire

// [sim/tb_breakpoint_trigger_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_breakpoint_trigger_unit;
    logic clk_i = 0, rstn_i = 0, ce_i = 1, csr_valid_i = 0, csr_write_i = 0, csr_debug_mode_i = 0;
    logic [11:0] csr_addr_i = 12'h000;
    logic [31:0] csr_wdata_i = 32'h0000_0000, acc_addr_i, csr_rdata_o, trap_cause_o, trap_badaddr_o;
    logic acc_valid_i, acc_load_i, acc_store_i, acc_fetch_i, csr_ready_o, csr_illegal_o, trap_valid_o, trap_to_debug_o;
    logic [2:0] acc_bytes_m1_i;
    logic [1:0] acc_priv_i;
    logic [btu_pkg::NUM_BP-1:0] bp_hit_o;
    int err_total = 0, check_count = 0, cyc = 0;
    typedef struct {logic [11:0] ctl; logic [31:0] bpa, a; logic [2:0] n, k; logic [1:0] p; logic hit;} btu_row_t;
    btu_row_t rows [12] = '{
        '{12'h000, 32'h0000_0100, 32'h0000_0100, 3'h0, 3'h4, 2'h3, 1'b1},
        '{12'h000, 32'h0000_0100, 32'h0000_0101, 3'h0, 3'h4, 2'h3, 1'b0},
        '{12'h000, 32'h0000_0100, 32'h0000_00fe, 3'h3, 3'h4, 2'h3, 1'b1},
        '{12'h004, 32'h0000_0100, 32'h0000_0100, 3'h0, 3'h2, 2'h3, 1'b0},
        '{12'h002, 32'h0000_0100, 32'h0000_0100, 3'h0, 3'h2, 2'h3, 1'b1},
        '{12'h001, 32'h0000_0100, 32'h0000_0100, 3'h0, 3'h1, 2'h0, 1'b1},
        '{12'h040, 32'h0000_0100, 32'h0000_0100, 3'h0, 3'h4, 2'h0, 1'b0},
        '{12'h028, 32'h0000_0100, 32'h0000_0100, 3'h0, 3'h4, 2'h2, 1'b1},
        '{12'h100, 32'h0000_1001, 32'h0000_1003, 3'h0, 3'h4, 2'h3, 1'b1},
        '{12'h100, 32'h0000_1001, 32'h0000_1004, 3'h0, 3'h4, 2'h3, 1'b0},
        '{12'h100, 32'h3fff_ffff, 32'h7000_0000, 3'h0, 3'h4, 2'h3, 1'b1},
        '{12'h100, 32'h3fff_ffff, 32'h8000_0000, 3'h0, 3'h4, 2'h3, 1'b0}};
    btu_unit i_dut (.*);
    btu_hart_model i_hart (.clk_i(clk_i), .acc_valid_o(acc_valid_i), .acc_addr_o(acc_addr_i),
        .acc_bytes_m1_o(acc_bytes_m1_i), .acc_kind_o({acc_load_i, acc_store_i, acc_fetch_i}), .acc_priv_o(acc_priv_i));
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic csr(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        #1;
        {csr_valid_i, csr_write_i, csr_addr_i, csr_wdata_i} = {1'b1, w, a, d};
        @(posedge clk_i);
        #1;
        csr_valid_i = 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        rstn_i = 1'b1;
        csr(0, btu_pkg::CSR_SELECT, 0);
        `CHK(csr_rdata_o, 32'h8000_0000)
        `CHK(csr_ready_o, 1'b1)
        csr(0, btu_pkg::CSR_CONTROL, 0);
        `CHK(csr_rdata_o, 32'h1f80_0000)
        csr(0, btu_pkg::CSR_RESERVED, 0);
        `CHK(csr_rdata_o, 32'h0000_0000)
        csr(1, btu_pkg::CSR_CONTROL, 32'hffff_ffff);
        csr(0, btu_pkg::CSR_CONTROL, 0);
        `CHK(csr_rdata_o & 32'hff87_ffff, 32'h1f80_007f)
        csr(1, btu_pkg::CSR_CONTROL, 32'h0000_0080);
        csr(0, btu_pkg::CSR_CONTROL, 0);
        `CHK(csr_rdata_o, 32'h1f80_0000)
        csr(1, btu_pkg::CSR_ADDRESS, 32'ha5a5_5a5a);
        csr(0, btu_pkg::CSR_ADDRESS, 0);
        `CHK(csr_rdata_o, 32'ha5a5_5a5a)
        foreach (rows[i]) begin
            csr(1, btu_pkg::CSR_CONTROL, {20'h0_0000, rows[i].ctl});
            csr(1, btu_pkg::CSR_ADDRESS, rows[i].bpa);
            i_hart.issue(rows[i].a, rows[i].n, rows[i].k, rows[i].p);
            `CHK(bp_hit_o[0], rows[i].hit)
            `CHK(trap_valid_o, rows[i].hit)
        end
        csr(1, btu_pkg::CSR_SELECT, 32'h8000_0007);
        csr(0, btu_pkg::CSR_SELECT, 0);
        `CHK(csr_rdata_o, 32'h8000_0003)
        // Range pair: bp0 low bound, bp1 one past the top
        csr(1, btu_pkg::CSR_SELECT, 32'h8000_0000);
        csr(1, btu_pkg::CSR_CONTROL, 0);
        csr(1, btu_pkg::CSR_ADDRESS, 32'h0000_0200);
        csr(1, btu_pkg::CSR_SELECT, 32'h8000_0001);
        csr(1, btu_pkg::CSR_CONTROL, 32'h0000_0080);
        csr(1, btu_pkg::CSR_ADDRESS, 32'h0000_0210);
        i_hart.issue(32'h0000_020f, 0, 4, 3);
        `CHK(bp_hit_o, 4'b0010)
        i_hart.issue(32'h0000_0200, 0, 4, 3);
        `CHK(bp_hit_o, 4'b0011)
        `CHK(trap_badaddr_o, 32'h0000_0200)
        `CHK(trap_cause_o, btu_pkg::CAUSE_BREAKPOINT)
        i_hart.issue(32'h0000_0210, 0, 4, 3);
        `CHK(bp_hit_o, 4'b0000)
        csr_debug_mode_i = 1'b1;
        csr(1, btu_pkg::CSR_SELECT, 32'h0000_0001);
        csr(1, btu_pkg::CSR_CONTROL, 32'h0000_0080);
        i_hart.issue(32'h0000_0208, 0, 4, 3);
        `CHK(trap_to_debug_o, 1'b1)
        `CHK(trap_cause_o, 32'h0000_0000)
        `CHK(trap_badaddr_o, 32'h0000_0000)
        csr_debug_mode_i = 1'b0;
        csr(0, btu_pkg::CSR_CONTROL, 0);
        `CHK(csr_illegal_o, 1'b1)
        csr(1, btu_pkg::CSR_SELECT, 32'h0000_0001);
        csr(0, btu_pkg::CSR_CONTROL, 0);
        `CHK(csr_rdata_o, 32'h0000_0000)
        // Reset in mid-run: machine view, index 0, ownership dropped
        @(posedge clk_i);
        #1;
        rstn_i = 1'b0;
        @(posedge clk_i);
        #1;
        `CHK(csr_ready_o, 1'b0)
        `CHK(trap_valid_o, 1'b0)
        rstn_i = 1'b1;
        csr(0, btu_pkg::CSR_SELECT, 0);
        `CHK(csr_rdata_o, 32'h8000_0000)
        csr(0, btu_pkg::CSR_CONTROL, 0);
        `CHK(csr_rdata_o, 32'h1f80_0000)
        // Clock enable low: the write is not taken, the old answer stands
        ce_i = 1'b0;
        csr(1, btu_pkg::CSR_ADDRESS, 32'h0000_5555);
        `CHK(csr_ready_o, 1'b1)
        ce_i = 1'b1;
        csr(0, btu_pkg::CSR_ADDRESS, 0);
        `CHK(csr_rdata_o, 32'h0000_0000)
        stop_test();
    end
endmodule // tb_breakpoint_trigger_unit
`default_nettype wire
